/* dcr_pkg.sv */
package dcr_pkg;
    // ------------------------------------------------------------
    // Pin positions on port 4
    // ------------------------------------------------------------
    localparam int P4_W = 8;
    localparam int PIN_RX2 = 4;
    localparam int PIN_RX1 = 5;
    localparam int PIN_TX1 = 6;
    localparam int PIN_TX2 = 7;
    localparam int SEG_LINES = 4;
    localparam int NUM_MODULES = 2;
    localparam int IRQ_LINES = 4;
    localparam int ADDR_SEL_BIT = 8;
    localparam int MODULE_ADDR_W = 16;
    localparam int MSG_OBJECTS_EACH = 32;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0] MODULE_EN_RESET = 2'h1;
    localparam logic [P4_W-1:0] PORT4_RESET = 8'h00;

    typedef struct packed {
        logic [P4_W-1:0] port4_data;
        logic [P4_W-1:0] port4_direction;
        logic [P4_W-1:0] port4_open_drain_ctrl;
    } dcr_port_cfg_t;

    typedef struct packed {
        logic [P4_W-1:0] out;
        logic [P4_W-1:0] oe;
    } dcr_pin_drive_t;

    typedef struct packed {
        logic scl_out;
        logic sda_out;
    } dcr_two_wire_t;
endpackage

/* dcr_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module dcr_sync #(
    parameter int W = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } dcr_sync_state_t;

    dcr_sync_state_t st;
    dcr_sync_state_t next_st;

    // First stage feeds only the second stage
    always_comb begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            // Idle pins sit high; ones avoid a false dominant after reset
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.s2;
endmodule
`default_nettype wire

/* dcr_port_routing.sv */
`timescale 1ns/100ps
`default_nettype none
module dcr_port_routing (
    input wire logic mclk,
    input wire logic rst,
    // ------------------------------------------------------------
    // Configuration bits
    // ------------------------------------------------------------
    input wire logic cfg_write,
    input wire logic [1:0] cfg_bus_module_enable,
    input wire logic cfg_misc_reg_access_enable,
    input wire logic cfg_two_wire_module_enable,
    input wire logic periph_bus_global_enable,
    input wire logic misc_write,
    input wire logic misc_parallel_bus_map,
    input wire logic port_write,
    input wire dcr_pkg::dcr_port_cfg_t port_cfg,
    // ------------------------------------------------------------
    // Module side
    // ------------------------------------------------------------
    input wire logic [dcr_pkg::MODULE_ADDR_W-1:0] module_addr,
    input wire logic module_access,
    input wire logic first_module_transmit,
    input wire logic second_module_transmit,
    input wire logic [dcr_pkg::IRQ_LINES-1:0] first_module_irq,
    input wire logic [dcr_pkg::IRQ_LINES-1:0] second_module_irq,
    input wire logic [dcr_pkg::IRQ_LINES-1:0] other_periph_irq,
    input wire dcr_pkg::dcr_two_wire_t two_wire_drive,
    // ------------------------------------------------------------
    // Port 4 pins
    // ------------------------------------------------------------
    input wire logic [dcr_pkg::P4_W-1:0] port4_pin_in,
    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    output logic [1:0] bus_module_enable,
    output logic two_wire_module_enable,
    output logic parallel_bus_map,
    output logic [1:0] module_select,
    output logic first_module_receive,
    output logic second_module_receive,
    output logic [dcr_pkg::IRQ_LINES-1:0] periph_irq,
    output logic [dcr_pkg::SEG_LINES-1:0] seg_line_limit,
    output logic seg_limited,
    output logic [dcr_pkg::P4_W-1:0] port4_read,
    output logic scl_in,
    output logic sda_in,
    output dcr_pkg::dcr_pin_drive_t port4_drive
);
    import dcr_pkg::*;

    typedef struct packed {
        logic [1:0] mod_en;
        logic tw_en;
        logic par_map;
        dcr_port_cfg_t port;
        logic [1:0] sel;
        logic rx1;
        logic rx2;
        logic [IRQ_LINES-1:0] irq;
        logic seg_lim;
        logic scl;
        logic sda;
        dcr_pin_drive_t drv;
    } dcr_state_t;

    dcr_state_t st;
    dcr_state_t next_st;
    logic [P4_W-1:0] pin_sync;
    wire logic [P4_W-1:0] dflt_out;
    wire logic [P4_W-1:0] dflt_oe;

    // Pins are asynchronous to mclk
    dcr_sync #(.W(P4_W)) u_sync (
        .mclk(mclk),
        .rst(rst),
        .d(port4_pin_in),
        .q(pin_sync)
    );

    // ------------------------------------------------------------
    // Plain port pin drive, one slice per pin
    // ------------------------------------------------------------
    // Open-drain pin driving high lets go for the pull-up
    for (genvar g = 0; g < P4_W; g++) begin : g_pin
        assign dflt_out[g] = st.port.port4_data[g];
        assign dflt_oe[g] = st.port.port4_direction[g]
            && !(st.port.port4_open_drain_ctrl[g] && st.port.port4_data[g]);
    end

    // Frame handling for 11/29-bit identifiers lives in the modules
    // Shared bus gives 2 x MSG_OBJECTS_EACH objects; pins wired outside

    always_comb begin
        logic tx_any_dominant;
        logic [P4_W-1:0] p_out;
        logic [P4_W-1:0] p_oe;
        tx_any_dominant = 1'b0;
        p_out = dflt_out;
        p_oe = dflt_oe;
        next_st = st;
        // ------------------------------------------------------------
        // Configuration
        // ------------------------------------------------------------
        // Enables sampled as written; ordering left to software
        if (cfg_write) begin
            next_st.mod_en = cfg_bus_module_enable;
            next_st.tw_en = cfg_two_wire_module_enable;
        end
        // Write ignored unless both access enables set
        if (misc_write && cfg_misc_reg_access_enable && periph_bus_global_enable) begin
            next_st.par_map = misc_parallel_bus_map;
        end
        if (port_write) begin
            next_st.port = port_cfg;
        end
        // ------------------------------------------------------------
        // Module decode and interrupts
        // ------------------------------------------------------------
        // Disabled module never selected, so stray accesses are harmless
        next_st.sel[0] = module_access && !module_addr[ADDR_SEL_BIT] && st.mod_en[0];
        next_st.sel[1] = module_access && module_addr[ADDR_SEL_BIT] && st.mod_en[1];
        next_st.irq = first_module_irq | second_module_irq | other_periph_irq;
        next_st.seg_lim = |st.mod_en;
        // ------------------------------------------------------------
        // Pin routing
        // ------------------------------------------------------------
        if (st.par_map) begin
            // Recessive high; either dominant pulls the shared pin low
            tx_any_dominant = (st.mod_en[0] && !first_module_transmit)
                || (st.mod_en[1] && !second_module_transmit);
            next_st.rx1 = pin_sync[PIN_RX1];
            next_st.rx2 = pin_sync[PIN_RX1];
            // P4.7 left to port or two-wire; second transmit shares P4.6 with the first
            if (|st.mod_en) begin
                p_out[PIN_TX1] = tx_any_dominant ? 1'b0 : 1'b1;
                p_oe[PIN_TX1] = tx_any_dominant
                    || !st.port.port4_open_drain_ctrl[PIN_TX1];
            end
        end else begin
            next_st.rx1 = pin_sync[PIN_RX1];
            next_st.rx2 = pin_sync[PIN_RX2];
            if (st.mod_en[0]) begin
                p_out[PIN_TX1] = first_module_transmit;
                p_oe[PIN_TX1] = !first_module_transmit
                    || !st.port.port4_open_drain_ctrl[PIN_TX1];
            end
            if (st.mod_en[1] && !st.tw_en) begin
                p_out[PIN_TX2] = second_module_transmit;
                p_oe[PIN_TX2] = !second_module_transmit
                    || !st.port.port4_open_drain_ctrl[PIN_TX2];
            end
        end
        // ------------------------------------------------------------
        // Two-wire takeover
        // ------------------------------------------------------------
        // Two-wire owns P4.4/P4.7; port registers lose control
        if (st.tw_en) begin
            p_out[PIN_RX2] = 1'b0;
            p_oe[PIN_RX2] = !two_wire_drive.scl_out;
            p_out[PIN_TX2] = 1'b0;
            p_oe[PIN_TX2] = !two_wire_drive.sda_out;
        end
        // Otherwise the port loop above governs them, save P4.7 when the second module transmits there
        next_st.scl = pin_sync[PIN_RX2];
        next_st.sda = pin_sync[PIN_TX2];
        next_st.drv.out = p_out;
        next_st.drv.oe = p_oe;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            st <= '0;
            st.mod_en <= MODULE_EN_RESET;
            st.port.port4_data <= PORT4_RESET;
            // Receive lines idle recessive so no false start bit
            st.rx1 <= 1'b1;
            st.rx2 <= 1'b1;
            st.scl <= 1'b1;
            st.sda <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bus_module_enable = st.mod_en;
    assign two_wire_module_enable = st.tw_en;
    assign parallel_bus_map = st.par_map;
    assign module_select = st.sel;
    assign first_module_receive = st.rx1;
    assign second_module_receive = st.rx2;
    assign periph_irq = st.irq;
    assign seg_line_limit = {SEG_LINES{st.seg_lim}};
    assign seg_limited = st.seg_lim;
    assign port4_read = pin_sync;
    assign scl_in = st.scl;
    assign sda_in = st.sda;
    assign port4_drive = st.drv;
endmodule
`default_nettype wire

/* dcr_xcvr.sv */
`timescale 1ns/100ps
`default_nettype none
module dcr_xcvr
    import dcr_pkg::*;
(
    input wire logic remote_dom,
    input wire dcr_pin_drive_t drv,
    output logic [P4_W-1:0] pins
);
    logic [P4_W-1:0] lvl;
    always_comb begin
        // Released pins rise through pull-ups, never hold a stale level
        lvl = drv.out | ~drv.oe;
        pins = lvl;
        // Any dominant node wins the wired bus
        pins[PIN_RX1] = lvl[PIN_RX1] & lvl[PIN_TX1] & !remote_dom;
        pins[PIN_RX2] = lvl[PIN_RX2] & lvl[PIN_TX2] & !remote_dom;
    end
endmodule
`default_nettype wire

/* dcr_port_routing_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module dcr_chk
    import dcr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic cfg_misc_reg_access_enable,
    input wire logic periph_bus_global_enable,
    input wire logic misc_write,
    input wire logic misc_parallel_bus_map,
    input wire logic first_module_transmit,
    input wire logic second_module_transmit,
    input wire dcr_two_wire_t two_wire_drive,
    input wire logic [P4_W-1:0] port4_pin_in,
    input wire logic [1:0] bus_module_enable,
    input wire logic two_wire_module_enable,
    input wire logic parallel_bus_map,
    input wire logic first_module_receive,
    input wire logic second_module_receive,
    input wire logic seg_limited,
    input wire dcr_pin_drive_t port4_drive
);
    // Edges since reset; keeps $past away from reset-time values
    logic [1:0] age;
    logic gate;
    assign gate = cfg_misc_reg_access_enable & periph_bus_global_enable;
    always_ff @(posedge mclk) begin
        age <= rst ? 2'h0 : age + {1'b0, age != 2'h3};
    end
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    rst_enable_a: assert property ($fell(rst) |-> bus_module_enable == 2'h1)
        else $error("bad enable reset");
    misc_refused_a: assert property (misc_write && !gate |=> $stable(parallel_bus_map))
        else $error("map written while locked");
    misc_load_a: assert property (misc_write && gate |=>
        parallel_bus_map == $past(misc_parallel_bus_map)) else $error("map not loaded");
    seg_limit_a: assert property (age != 2'h0 |-> seg_limited == $past(|bus_module_enable))
        else $error("segment limit wrong");
    first_rx_a: assert property (age == 2'h3 |->
        first_module_receive == $past(port4_pin_in[PIN_RX1], 3)) else $error("first rx");
    second_rx_a: assert property (age == 2'h3 && $stable(parallel_bus_map) &&
        $past(parallel_bus_map, 2) == parallel_bus_map |-> second_module_receive ==
        (parallel_bus_map ? $past(port4_pin_in[PIN_RX1], 3) : $past(port4_pin_in[PIN_RX2], 3)))
        else $error("second rx");
    tx_normal_a: assert property (age != 2'h0 && $past(bus_module_enable[0] &&
        !parallel_bus_map) |-> port4_drive.out[PIN_TX1] == $past(first_module_transmit))
        else $error("first tx route");
    tx_parallel_a: assert property ($past(parallel_bus_map && bus_module_enable == 2'h3) |->
        port4_drive.out[PIN_TX1] == $past(first_module_transmit && second_module_transmit))
        else $error("parallel tx route");
    two_wire_a: assert property ($past(two_wire_module_enable) |->
        port4_drive.oe[PIN_RX2] == !$past(two_wire_drive.scl_out) &&
        port4_drive.oe[PIN_TX2] == !$past(two_wire_drive.sda_out)) else $error("two-wire pins");
    cover property (parallel_bus_map && !second_module_receive);
    cover property (two_wire_module_enable);
    cover property (misc_write && !gate);
endmodule
bind dcr_port_routing dcr_chk chk_u (.*);
`default_nettype wire

/* dcr_port_routing_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module dcr_port_routing_tb;
    import dcr_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, cfg_write = 1'b0, misc_write = 1'b0, port_write = 1'b0;
    logic cfg_misc_reg_access_enable = 1'b1, periph_bus_global_enable = 1'b0, remote = 1'b0;
    logic cfg_two_wire_module_enable = 1'b0, misc_parallel_bus_map = 1'b0, module_access = 1'b0;
    logic first_module_transmit = 1'b1, second_module_transmit = 1'b1;
    logic [1:0] cfg_bus_module_enable = 2'h1, bus_module_enable, module_select;
    logic [3:0] first_module_irq = 4'h0, second_module_irq = 4'h0, other_periph_irq = 4'h0;
    logic [15:0] module_addr = 16'h0000;
    dcr_port_cfg_t port_cfg = 24'h0000c0;
    dcr_two_wire_t two_wire_drive = 2'h3;
    dcr_pin_drive_t port4_drive;
    logic [7:0] port4_pin_in, port4_read;
    logic [3:0] periph_irq, seg_line_limit;
    logic two_wire_module_enable, parallel_bus_map, first_module_receive, second_module_receive;
    logic scl_in, sda_in, seg_limited;
    // Rows: map, enables, tx1, tx2 -> rx1, rx2
    logic [6:0] rows [8] = '{7'h03, 7'h15, 7'h3a, 7'h22, 7'h78, 7'h7f, 7'h5b, 7'h68};
    int fail_count = 0, n_compared = 0;
    dcr_port_routing dut_u (.*);
    dcr_xcvr xcvr_u (.remote_dom(remote), .drv(port4_drive), .pins(port4_pin_in));
    always #2 mclk = ~mclk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", fail_count, n_compared);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (1000) @(posedge mclk);
        fail_count++;
        end_of_test;
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        port_write <= 1'b1;
        tick(1);
        port_write <= 1'b0;
        chk(bus_module_enable, 2'h1);
        cfg_write <= 1'b1;
        tick(1);
        cfg_write <= 1'b0;
        periph_bus_global_enable <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            {misc_parallel_bus_map, cfg_bus_module_enable, first_module_transmit,
                second_module_transmit} <= rows[i][6:2];
            cfg_write <= 1'b1;
            misc_write <= 1'b1;
            @(posedge mclk);
            cfg_write <= 1'b0;
            misc_write <= 1'b0;
            tick(6);
            chk({first_module_receive, second_module_receive}, rows[i][1:0]);
            chk({seg_limited, seg_line_limit}, {5{|rows[i][5:4]}});
        end
        @(posedge mclk);
        periph_bus_global_enable <= 1'b0;
        misc_parallel_bus_map <= 1'b0;
        misc_write <= 1'b1;
        second_module_transmit <= 1'b1;
        remote <= 1'b1;
        @(posedge mclk);
        misc_write <= 1'b0;
        periph_bus_global_enable <= 1'b1;
        tick(6);
        chk(parallel_bus_map, 1'b1);
        chk({first_module_receive, second_module_receive}, 2'h0);
        @(posedge mclk);
        remote <= 1'b0;
        cfg_bus_module_enable <= 2'h3;
        cfg_write <= 1'b1;
        module_access <= 1'b1;
        module_addr <= 16'h0100;
        first_module_irq <= 4'h1;
        other_periph_irq <= 4'h8;
        @(posedge mclk);
        cfg_write <= 1'b0;
        tick(3);
        chk(module_select, 2'h2);
        chk(periph_irq, 4'h9);
        @(posedge mclk);
        module_addr <= 16'h0000;
        port_cfg <= 24'h009000;
        port_write <= 1'b1;
        @(posedge mclk);
        port_write <= 1'b0;
        tick(3);
        chk(module_select, 2'h1);
        chk({port4_drive.oe[PIN_RX2], port4_drive.out[PIN_RX2]}, 2'h2);
        @(posedge mclk);
        cfg_two_wire_module_enable <= 1'b1;
        cfg_write <= 1'b1;
        two_wire_drive <= 2'h1;
        @(posedge mclk);
        cfg_write <= 1'b0;
        tick(5);
        chk({port4_drive.oe[PIN_RX2], port4_drive.oe[PIN_TX2]}, 2'h2);
        chk({two_wire_module_enable, scl_in, sda_in}, 3'h5);
        chk(port4_read, 8'hef);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        tick(1);
        chk({parallel_bus_map, bus_module_enable}, 3'h1);
        chk({first_module_receive, second_module_receive, scl_in, sda_in}, 4'hf);
        end_of_test;
    end
endmodule
`default_nettype wire
